// ===== core/osd_attribute_luma_control.sv
// OSD per-dot attribute logic: italic, underline, flash, border, solid space
// and the two luminance-control outputs.
// Assumes the OSD engine presents one half-dot sample per clock on the same clock;
// vertical sync comes from a pin and is synchronised here.

`timescale 1ns/10ps
`default_nettype none

module osd_attribute_luma_control (
  input wire logic CLK_SYS,
  input wire logic RESETN,
  // Wishbone classic slave
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  // Vertical sync pin
  input wire logic VSYNC_PIN,
  // Dot stream from the OSD engine
  input wire logic PIX_VALID,
  input wire logic END_CELL,
  input wire logic [4:0] DOT_POS,
  input wire logic [4:0] LINE,
  input wire logic [15:0] FONT_ROW,
  input wire logic [15:0] PREV_FONT_ROW,
  input wire logic [15:0] NEXT_FONT_ROW,
  input wire logic [15:0] FONT_ROW_ABOVE,
  input wire logic [15:0] FONT_ROW_BELOW,
  input wire logic [9:0] CHAR_CODE,
  input wire logic CHAR_ITALIC_ATTR,
  input wire logic CHAR_FLASH_ATTR,
  input wire logic CHAR_UNDERLINE_ATTR,
  input wire logic CHAR_OUT_SELECT_ATTR,
  input wire logic PREV_ITALIC_ATTR,
  input wire logic NEXT_ITALIC_ATTR,
  input wire logic PAL_LUMA_BIT,
  input wire logic [2:0] BLOCK_CTRL,
  // Dot outputs
  output logic LUMA_CTRL_PRIMARY_OUT,
  output logic LUMA_CTRL_SECONDARY_OUT,
  output logic FONT_COLOR_ON,
  output logic BG_COLOR_ON,
  output logic BORDER_ON,
  output logic FORCE_PALETTE8
);

  // ****************************************
  // Helpers
  // ****************************************
  // Font bit at a half-dot position relative to the current cell start
  function automatic logic font_at(input logic [47:0] row, input logic signed [6:0] pos);
    logic signed [7:0] p;
    logic [5:0] d;
    p = 8'(pos) + 8'sd32;
    d = p[6:1];
    if (p < 8'sd0 || p > 8'sd95) begin
      font_at = 1'b0;
    end else begin
      font_at = row[6'd47 - d];
    end
  endfunction : font_at

  // ****************************************
  // Register bus
  // ****************************************
  logic [7:0] ctrl_q;
  logic ack_q;
  logic [31:0] rdat_q;
  logic bus_req;
  logic flash_on_q;
  logic [5:0] flash_cnt_q;

  assign bus_req = WB_CYC_I && WB_STB_I && !ack_q;

  always_ff @(posedge CLK_SYS) begin
    if (!RESETN) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= bus_req;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RESETN) begin
      ctrl_q <= osd_luma_pkg::CTRL_RESET;
    end else if (bus_req && WB_WE_I && WB_SEL_I[0] && WB_ADR_I == osd_luma_pkg::REG_CTRL) begin
      ctrl_q <= WB_DAT_I[7:0];
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RESETN) begin
      rdat_q <= 32'h0000_0000;
    end else if (bus_req && !WB_WE_I) begin
      unique case (WB_ADR_I)
        osd_luma_pkg::REG_CTRL: rdat_q <= {24'h00_0000, ctrl_q};
        osd_luma_pkg::REG_STATUS: rdat_q <= {25'h000_0000, flash_on_q, flash_cnt_q};
        default: rdat_q <= 32'h0000_0000;
      endcase
    end
  end

  assign WB_ACK_O = ack_q;
  assign WB_DAT_O = rdat_q;

  // ****************************************
  // Flash phase
  // ****************************************
  logic vs_meta_q;
  logic vs_sync_q;
  logic vs_prev_q;
  logic vs_edge;
  logic [5:0] flash_limit;

  always_ff @(posedge CLK_SYS) begin
    if (!RESETN) begin
      vs_meta_q <= 1'b0;
      vs_sync_q <= 1'b0;
      vs_prev_q <= 1'b0;
    end else begin
      vs_meta_q <= VSYNC_PIN;
      vs_sync_q <= vs_meta_q;
      vs_prev_q <= vs_sync_q;
    end
  end

  assign vs_edge = vs_sync_q && !vs_prev_q;
  assign flash_limit = !flash_on_q ? osd_luma_pkg::FLASH_OFF :
                       ctrl_q[osd_luma_pkg::CTRL_FLASH_LONG] ? osd_luma_pkg::FLASH_ON_LONG :
                       osd_luma_pkg::FLASH_ON_SHORT;

  // Shared by every flashing character so all flash together
  always_ff @(posedge CLK_SYS) begin
    if (!RESETN) begin
      flash_on_q <= 1'b1;
      flash_cnt_q <= 6'h00;
    end else if (vs_edge) begin
      if (flash_cnt_q >= flash_limit - 6'h01) begin
        flash_on_q <= !flash_on_q;
        flash_cnt_q <= 6'h00;
      end else begin
        flash_cnt_q <= flash_cnt_q + 6'h01;
      end
    end
  end

  // ****************************************
  // Italic slant and font dot
  // ****************************************
  logic caption;
  logic [4:0] line_c;
  logic [4:0] up;
  logic [4:0] shift_h;
  logic signed [6:0] pos;
  logic signed [6:0] sh;
  logic cur_eff;
  logic prev_eff;
  logic font_cur;
  logic font_spill;
  logic font_dot;
  logic underline;
  logic fg;

  assign caption = ctrl_q[osd_luma_pkg::CTRL_CAPTION];
  assign line_c = (LINE > osd_luma_pkg::FONT_LAST_LINE) ? osd_luma_pkg::FONT_LAST_LINE : LINE;
  assign up = osd_luma_pkg::FONT_LAST_LINE - line_c;
  assign shift_h = ctrl_q[osd_luma_pkg::CTRL_RATIO2] ? {1'b0, up[4:1]} : {up[4:2], 1'b0};
  assign pos = signed'({2'b00, DOT_POS});
  assign sh = signed'({2'b00, shift_h});
  assign cur_eff = caption && !END_CELL && (CHAR_ITALIC_ATTR || PREV_ITALIC_ATTR || NEXT_ITALIC_ATTR);
  assign prev_eff = caption && (PREV_ITALIC_ATTR || CHAR_ITALIC_ATTR);
  assign font_cur = !END_CELL && font_at({16'h0000, FONT_ROW, 16'h0000}, cur_eff ? pos - sh : pos);
  assign font_spill = prev_eff && (!END_CELL || ctrl_q[osd_luma_pkg::CTRL_SOLID_EN]) &&
                      font_at({PREV_FONT_ROW, 32'h0000_0000}, pos - sh);
  assign font_dot = PIX_VALID && (font_cur || font_spill);
  assign underline = PIX_VALID && caption && !END_CELL && CHAR_UNDERLINE_ATTR &&
                     (LINE == osd_luma_pkg::UL_LINE_FIRST || LINE == osd_luma_pkg::UL_LINE_SECOND);
  assign fg = font_dot || underline;

  // ****************************************
  // Border
  // ****************************************
  logic [47:0] row_all;
  logic wide;
  logic bd_right;
  logic bd_left;
  logic bd_below;
  logic bd_above;
  logic border;

  assign row_all = {PREV_FONT_ROW, FONT_ROW, NEXT_FONT_ROW};
  assign wide = ctrl_q[osd_luma_pkg::CTRL_RATIO2] && ctrl_q[osd_luma_pkg::CTRL_SIZE15];
  assign bd_right = font_at(row_all, pos - 7'sd2) || (wide && font_at(row_all, pos - 7'sd3));
  assign bd_left = font_at(row_all, pos + 7'sd2) || (wide && font_at(row_all, pos + 7'sd3));
  assign bd_below = LINE != 5'h00 && font_at({16'h0000, FONT_ROW_ABOVE, 16'h0000}, pos);
  assign bd_above = LINE < osd_luma_pkg::FONT_LAST_LINE &&
                    font_at({16'h0000, FONT_ROW_BELOW, 16'h0000}, pos);
  assign border = PIX_VALID && !caption && !END_CELL && BLOCK_CTRL[osd_luma_pkg::BLK_BORDER_EN] &&
                  !fg &&
                  (bd_right || bd_below ||
                   (!ctrl_q[osd_luma_pkg::CTRL_SHADOW] && (bd_left || bd_above)));

  // ****************************************
  // Flash, solid space and luma outputs
  // ****************************************
  logic flash_blank;
  logic blank_all;
  logic solid_en;
  logic solid_sec;
  logic solid_cell;
  logic area;
  logic fg_on;
  logic bg_on;
  logic prim_base;
  logic prim_d;
  logic sec_d;

  assign flash_blank = caption && CHAR_FLASH_ATTR && !flash_on_q && !END_CELL;
  assign blank_all = flash_blank && ctrl_q[osd_luma_pkg::CTRL_FLASH_SCOPE];
  assign solid_en = caption && ctrl_q[osd_luma_pkg::CTRL_SOLID_EN];
  assign solid_sec = ctrl_q[osd_luma_pkg::CTRL_SOLID_SEC];
  assign solid_cell = solid_en && PIX_VALID && (END_CELL || CHAR_CODE != osd_luma_pkg::SPACE_CODE);
  assign area = PIX_VALID && !END_CELL;
  assign fg_on = fg && !flash_blank;
  assign bg_on = area && !border && !fg_on && !blank_all;
  assign prim_base = (area && BLOCK_CTRL[osd_luma_pkg::BLK_PRIMARY_EN] && PAL_LUMA_BIT) ||
                     border || (font_spill && PIX_VALID);
  assign prim_d = ((solid_en && !solid_sec) ? solid_cell : prim_base) &&
                  !(blank_all && !solid_cell);
  // Secondary output is never blanked by flash
  assign sec_d = (area && CHAR_OUT_SELECT_ATTR && BLOCK_CTRL[osd_luma_pkg::BLK_SECONDARY_EN]) ||
                 (solid_sec && solid_cell);

  always_ff @(posedge CLK_SYS) begin
    if (!RESETN) begin
      LUMA_CTRL_PRIMARY_OUT <= 1'b0;
      LUMA_CTRL_SECONDARY_OUT <= 1'b0;
      FONT_COLOR_ON <= 1'b0;
      BG_COLOR_ON <= 1'b0;
      BORDER_ON <= 1'b0;
      FORCE_PALETTE8 <= 1'b0;
    end else begin
      LUMA_CTRL_PRIMARY_OUT <= prim_d;
      LUMA_CTRL_SECONDARY_OUT <= sec_d;
      FONT_COLOR_ON <= fg_on && !blank_all;
      BG_COLOR_ON <= bg_on || (solid_cell && END_CELL);
      BORDER_ON <= border;
      FORCE_PALETTE8 <= border || (solid_cell && !solid_sec && !fg_on);
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  sequence wb_req_s;
    WB_CYC_I && WB_STB_I && !ack_q;
  endsequence

  sequence wb_ctrl_wr_s;
    wb_req_s ##0 (WB_WE_I && WB_SEL_I[0] && WB_ADR_I == osd_luma_pkg::REG_CTRL);
  endsequence

  bus_ack_pulse_a: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    wb_req_s |=> WB_ACK_O ##1 !WB_ACK_O)
    else $error("Bus ack not a single pulse");

  ctrl_write_a: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    wb_ctrl_wr_s |=> ctrl_q == $past(WB_DAT_I[7:0]))
    else $error("Control write not stored");

  flash_off_len_a: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    $rose(flash_on_q) |-> $past(flash_cnt_q) == 6'h07)
    else $error("Flash off phase length wrong");

  flash_on_len_a: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    $fell(flash_on_q) && !$past(ctrl_q[osd_luma_pkg::CTRL_FLASH_LONG]) |->
    $past(flash_cnt_q) >= 6'h17)
    else $error("Flash on phase too short");

  flash_restart_a: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    flash_on_q != $past(flash_on_q) |-> flash_cnt_q == 6'h00)
    else $error("Flash counter not restarted");

  underline_draw_a: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    underline && !flash_blank |=> FONT_COLOR_ON)
    else $error("Underline not drawn");

  flash_primary_a: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    blank_all && !solid_cell |=> !LUMA_CTRL_PRIMARY_OUT && !FONT_COLOR_ON)
    else $error("Primary luma not blanked by flash");

  border_font_a: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    BORDER_ON |-> !FONT_COLOR_ON && FORCE_PALETTE8 && LUMA_CTRL_PRIMARY_OUT)
    else $error("Border drawn over font or off palette 8");

  space_code_a: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    solid_en && !solid_sec && area && CHAR_CODE == osd_luma_pkg::SPACE_CODE |=>
    !LUMA_CTRL_PRIMARY_OUT)
    else $error("Solid space on space code cell");

  solid_pal8_a: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    solid_cell && !solid_sec && !fg_on |=> FORCE_PALETTE8 && LUMA_CTRL_PRIMARY_OUT)
    else $error("Solid background not palette 8");

  secondary_attr_a: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    area && CHAR_OUT_SELECT_ATTR && BLOCK_CTRL[osd_luma_pkg::BLK_SECONDARY_EN] |=>
    LUMA_CTRL_SECONDARY_OUT)
    else $error("Secondary luma missing for output attribute");

endmodule : osd_attribute_luma_control

`default_nettype wire

// ===== core/osd_luma_pkg.sv
// Constants for the OSD attribute and luminance-control block.
// Assumes a single 40 MHz system clock and a Wishbone classic register bus.

package osd_luma_pkg;

  // ****************************************
  // Register map (byte addresses)
  // ****************************************
  localparam int ADR_WIDTH = 8;
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;

  // ****************************************
  // Control register fields
  // ****************************************
  localparam int CTRL_WIDTH = 8;
  localparam int CTRL_CAPTION = 0;
  localparam int CTRL_RATIO2 = 1;
  localparam int CTRL_SHADOW = 2;
  localparam int CTRL_FLASH_SCOPE = 3;
  localparam int CTRL_FLASH_LONG = 4;
  localparam int CTRL_SOLID_EN = 5;
  localparam int CTRL_SOLID_SEC = 6;
  localparam int CTRL_SIZE15 = 7;
  localparam logic [7:0] CTRL_RESET = 8'h01;

  // ****************************************
  // Block control bits
  // ****************************************
  localparam int BLK_BORDER_EN = 0;
  localparam int BLK_PRIMARY_EN = 1;
  localparam int BLK_SECONDARY_EN = 2;

  // ****************************************
  // Flash timing in vertical sync periods
  // ****************************************
  localparam logic [5:0] FLASH_ON_SHORT = 6'h18;
  localparam logic [5:0] FLASH_ON_LONG = 6'h30;
  localparam logic [5:0] FLASH_OFF = 6'h08;

  // ****************************************
  // Character cell geometry
  // ****************************************
  localparam logic [9:0] SPACE_CODE = 10'h009;
  localparam logic [4:0] UL_LINE_FIRST = 5'h16;
  localparam logic [4:0] UL_LINE_SECOND = 5'h17;
  localparam logic [4:0] FONT_LAST_LINE = 5'h13;

endpackage : osd_luma_pkg

// ===== tb/osd_attribute_luma_control_tb.sv
// Self-checking bench for the OSD attribute and luminance-control block.
// Assumes the design package, the design and the mixer model are compiled first.
`timescale 1ns/10ps
`default_nettype none

module osd_attribute_luma_control_tb;
  // ****************************************
  // Signals
  // ****************************************
  logic clk = 1'b0, rst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, vs = 1'b0, ec = 1'b0;
  logic pv = 1'b1, pi = 1'b0, pl = 1'b1;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0, at = 4'h0;
  logic [31:0] wdat = 32'h0, rdat;
  logic ack, lp, ls, fc, bg, bo, f8;
  logic [4:0] dpos = 5'h00, line = 5'h00;
  logic [15:0] fr = 16'h0000;
  logic [9:0] code = 10'h041;
  logic [2:0] blk = 3'h7, mix;
  int n_mismatch = 0, compares = 0, cycles = 0;

  always #12.5 clk = ~clk;

  osd_attribute_luma_control dut (.CLK_SYS(clk), .RESETN(rst_n), .WB_CYC_I(cyc), .WB_STB_I(stb),
    .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
    .VSYNC_PIN(vs), .PIX_VALID(pv), .END_CELL(ec), .DOT_POS(dpos), .LINE(line), .FONT_ROW(fr),
    .PREV_FONT_ROW(16'h0000), .NEXT_FONT_ROW(16'h0000), .FONT_ROW_ABOVE(16'h0000),
    .FONT_ROW_BELOW(16'h0000), .CHAR_CODE(code), .CHAR_ITALIC_ATTR(at[3]), .CHAR_FLASH_ATTR(at[2]),
    .CHAR_UNDERLINE_ATTR(at[1]), .CHAR_OUT_SELECT_ATTR(at[0]), .PREV_ITALIC_ATTR(pi),
    .NEXT_ITALIC_ATTR(1'b0), .PAL_LUMA_BIT(pl), .BLOCK_CTRL(blk), .LUMA_CTRL_PRIMARY_OUT(lp),
    .LUMA_CTRL_SECONDARY_OUT(ls), .FONT_COLOR_ON(fc), .BG_COLOR_ON(bg), .BORDER_ON(bo),
    .FORCE_PALETTE8(f8));

  tv_mixer_model mix_i (.clk(clk), .primary(lp), .secondary(ls), .font_on(fc), .bg_on(bg),
    .border_on(bo), .force8(f8), .mix_q(mix));

  // ****************************************
  // Compare and report tasks
  // ****************************************
  task automatic chk_w(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: word %h expected %h", $time, got, exp);
    end
  endtask : chk_w

  task automatic chk_b(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: bit %b expected %b", $time, got, exp);
    end
  endtask : chk_b

  task automatic final_report;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : final_report

  // ****************************************
  // Bus, dot and sync drivers
  // ****************************************
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                    output logic [31:0] q);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= s;
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : wb

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] q;
    wb(1'b1, a, d, s, q);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, 4'hF, q);
    chk_w(q, exp);
  endtask : rd

  task automatic dot(input logic [4:0] p, input logic [4:0] l, input logic [15:0] f,
                     input logic [9:0] c, input logic [3:0] a, input logic e);
    @(posedge clk);
    dpos <= p;
    line <= l;
    fr <= f;
    code <= c;
    at <= a;
    ec <= e;
    repeat (3) @(posedge clk);
    #1;
  endtask : dot

  task automatic vpulse(input int n);
    repeat (n) begin
      @(posedge clk);
      vs <= 1'b1;
      repeat (4) @(posedge clk);
      vs <= 1'b0;
      repeat (4) @(posedge clk);
    end
    repeat (4) @(posedge clk);
  endtask : vpulse

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_mismatch++;
      final_report();
    end
  end

  // ****************************************
  // Tests
  // ****************************************
  initial begin
    int on;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    rd(osd_luma_pkg::REG_CTRL, 32'h0000_0001);
    rd(osd_luma_pkg::REG_STATUS, 32'h0000_0040);
    rd(8'h10, 32'h0000_0000);
    wr(osd_luma_pkg::REG_CTRL, 32'h0000_00A5, 4'h0);
    rd(osd_luma_pkg::REG_CTRL, 32'h0000_0001);
    wr(osd_luma_pkg::REG_CTRL, 32'h0000_00A5, 4'h1);
    rd(osd_luma_pkg::REG_CTRL, 32'h0000_00A5);
    $display("test registers done");
    for (int k = 0; k < 2; k++) begin
      on = (k == 0) ? 24 : 48;
      wr(osd_luma_pkg::REG_CTRL, (k == 0) ? 32'h01 : 32'h11, 4'h1);
      dot(5'h00, 5'h00, 16'hFFFF, 10'h041, 4'b0101, 1'b0);
      vpulse(on - 1);
      chk_b(fc, 1'b1);
      rd(osd_luma_pkg::REG_STATUS, 32'h40 | (on - 1));
      vpulse(1);
      chk_b(fc, 1'b0);
      chk_b(ls, 1'b1);
      chk_b(lp, 1'b1);
      wr(osd_luma_pkg::REG_CTRL, (k == 0) ? 32'h09 : 32'h19, 4'h1);
      dot(5'h00, 5'h00, 16'hFFFF, 10'h041, 4'b0101, 1'b0);
      chk_b(lp, 1'b0);
      chk_b(bg, 1'b0);
      chk_b(ls, 1'b1);
      vpulse(7);
      chk_b(fc, 1'b0);
      vpulse(1);
      chk_b(fc, 1'b1);
    end
    $display("test flash done");
    wr(osd_luma_pkg::REG_CTRL, 32'h01, 4'h1);
    dot(5'h00, 5'h16, 16'h0000, 10'h041, 4'b0010, 1'b0);
    chk_b(fc, 1'b1);
    dot(5'h00, 5'h17, 16'h0000, 10'h041, 4'b0010, 1'b0);
    chk_b(fc, 1'b1);
    dot(5'h00, 5'h15, 16'h0000, 10'h041, 4'b0010, 1'b0);
    chk_b(fc, 1'b0);
    dot(5'h08, 5'h00, 16'h8000, 10'h041, 4'b1000, 1'b0);
    chk_b(fc, 1'b1);
    dot(5'h08, 5'h00, 16'h8000, 10'h041, 4'b0000, 1'b0);
    chk_b(fc, 1'b0);
    @(posedge clk) pi <= 1'b1;
    dot(5'h08, 5'h00, 16'h8000, 10'h041, 4'b0000, 1'b0);
    chk_b(fc, 1'b1);
    dot(5'h00, 5'h00, 16'h8000, 10'h041, 4'b1000, 1'b0);
    chk_b(fc, 1'b0);
    chk_b(bg, 1'b1);
    wr(osd_luma_pkg::REG_CTRL, 32'h03, 4'h1);
    dot(5'h09, 5'h00, 16'h8000, 10'h041, 4'b1000, 1'b0);
    chk_b(fc, 1'b1);
    dot(5'h08, 5'h00, 16'h8000, 10'h041, 4'b1000, 1'b0);
    chk_b(fc, 1'b0);
    @(posedge clk) pi <= 1'b0;
    $display("test italic done");
    wr(osd_luma_pkg::REG_CTRL, 32'h00, 4'h1);
    dot(5'h00, 5'h16, 16'h0000, 10'h041, 4'b0010, 1'b0);
    chk_b(fc, 1'b0);
    $display("test underline done");
    dot(5'h10, 5'h05, 16'h0100, 10'h041, 4'b0000, 1'b0);
    chk_b(bo, 1'b1);
    chk_b(lp, 1'b1);
    chk_b(f8, 1'b1);
    chk_b(bg, 1'b0);
    chk_w({29'h0, mix}, 32'h7);
    dot(5'h0C, 5'h05, 16'h0100, 10'h041, 4'b0000, 1'b0);
    chk_b(bo, 1'b1);
    wr(osd_luma_pkg::REG_CTRL, 32'h04, 4'h1);
    dot(5'h0C, 5'h05, 16'h0100, 10'h041, 4'b0000, 1'b0);
    chk_b(bo, 1'b0);
    dot(5'h10, 5'h05, 16'h0100, 10'h041, 4'b0000, 1'b0);
    chk_b(bo, 1'b1);
    @(posedge clk) blk <= 3'h6;
    dot(5'h10, 5'h05, 16'h0100, 10'h041, 4'b0000, 1'b0);
    chk_b(bo, 1'b0);
    @(posedge clk) blk <= 3'h7;
    @(posedge clk) pl <= 1'b0;
    dot(5'h00, 5'h05, 16'h0000, 10'h041, 4'b0000, 1'b0);
    chk_b(lp, 1'b0);
    chk_w({29'h0, mix}, 32'h1);
    @(posedge clk) pl <= 1'b1;
    dot(5'h00, 5'h05, 16'h0000, 10'h041, 4'b0000, 1'b0);
    chk_b(lp, 1'b1);
    $display("test border done");
    wr(osd_luma_pkg::REG_CTRL, 32'h21, 4'h1);
    dot(5'h00, 5'h05, 16'h0000, 10'h041, 4'b0000, 1'b0);
    chk_b(lp, 1'b1);
    chk_b(f8, 1'b1);
    @(posedge clk) pv <= 1'b0;
    dot(5'h00, 5'h05, 16'h0000, 10'h041, 4'b0000, 1'b0);
    chk_b(lp, 1'b0);
    @(posedge clk) pv <= 1'b1;
    dot(5'h00, 5'h05, 16'h0000, osd_luma_pkg::SPACE_CODE, 4'b0000, 1'b0);
    chk_b(lp, 1'b0);
    wr(osd_luma_pkg::REG_CTRL, 32'h61, 4'h1);
    dot(5'h00, 5'h05, 16'h0000, 10'h041, 4'b0000, 1'b0);
    chk_b(ls, 1'b1);
    dot(5'h00, 5'h05, 16'h0000, osd_luma_pkg::SPACE_CODE, 4'b0000, 1'b0);
    chk_b(ls, 1'b0);
    dot(5'h00, 5'h05, 16'h0000, osd_luma_pkg::SPACE_CODE, 4'b0000, 1'b1);
    chk_b(ls, 1'b1);
    dot(5'h00, 5'h05, 16'hFFFF, osd_luma_pkg::SPACE_CODE, 4'b0000, 1'b0);
    chk_b(fc, 1'b1);
    wr(osd_luma_pkg::REG_CTRL, 32'h01, 4'h1);
    dot(5'h00, 5'h05, 16'h0000, 10'h041, 4'b0000, 1'b0);
    chk_b(ls, 1'b0);
    dot(5'h00, 5'h05, 16'h0000, 10'h041, 4'b0001, 1'b0);
    chk_b(ls, 1'b1);
    $display("test solid space done");
    final_report();
  end
endmodule : osd_attribute_luma_control_tb

`default_nettype wire

// ===== tb/tv_mixer_model.sv
// Far-side model: the television luminance and colour mixer.
// Assumes the block's dot outputs arrive registered on the system clock.
`timescale 1ns/10ps
`default_nettype none

module tv_mixer_model (
  input wire logic clk,
  input wire logic primary,
  input wire logic secondary,
  input wire logic font_on,
  input wire logic bg_on,
  input wire logic border_on,
  input wire logic force8,
  output var logic [2:0] mix_q
);
  // ****************************************
  // Mixing: blanking wins over colour
  // ****************************************
  always_ff @(posedge clk) begin
    if (primary || secondary) begin
      mix_q <= {1'b1, primary, force8};
    end else begin
      mix_q <= {1'b0, font_on | border_on, bg_on};
    end
  end
endmodule : tv_mixer_model

`default_nettype wire
